// ==== design/buck_params.svh ====
// Offsets, field positions, reset values and timing counts of the regulator
`ifndef BUCK_PARAMS_SVH
`define BUCK_PARAMS_SVH
`define CLK_HZ 20000000
`define OFS_SETPOINT_A 8'h00
`define OFS_SETPOINT_B 8'h01
`define OFS_CONTROL 8'h02
`define OFS_STATUS 8'h05
`define OFS_SWITCHING 8'h06
`define BIT_SW_ON 7
`define BIT_MODE 6
`define BIT_BLEED 7
`define CODE_MSB 5
`define RST_SETPOINT 8'hC2
`define RST_CONTROL 8'h00
`define LIMIT_RUN 16
`define RETRY_MS 1700
`define RETRY_CYCLES (`RETRY_MS * (`CLK_HZ / 1000))
`define SS_STEP_US 5
`define SS_STEP_CYCLES (`SS_STEP_US * (`CLK_HZ / 1000000))
`define PFM_LEAVE_RUN 4
`endif

// ==== design/buck_pkg.sv ====
// Types shared by the regulator control modules
package buck_pkg;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SOFTSTART = 3'b001,
		ST_RUN = 3'b010,
		ST_RETRY = 3'b011
	} seq_state_t;
	typedef enum logic [1:0] {
		LM_PWM = 2'b00,
		LM_PFM = 2'b01
	} light_mode_t;
endpackage

// ==== design/buck_ctl_if.sv ====
// Signals between the sequencer and its helper modules
`timescale 1ns/10ps
interface buck_ctl_if;
	logic [5:0] target;
	logic ramp_run;
	logic [5:0] ref_code;
	logic ramp_done;
	logic cycle_end;
	logic limit_hit;
	logic count_clear;
	logic trip;
	modport seq (output target, output ramp_run, input ref_code,
		input ramp_done, input trip, output count_clear, input cycle_end,
		input limit_hit);
	modport ramp (input target, input ramp_run, output ref_code,
		output ramp_done);
	modport limit (input cycle_end, input limit_hit, input count_clear,
		output trip);
endinterface

// ==== design/softstart_ramp.sv ====
// Reference ramp that walks toward the selected setpoint code
`timescale 1ns/10ps
`include "buck_params.svh"
module softstart_ramp (
	input wire logic clk_i,
	input wire logic nrst_i,
	buck_ctl_if.ramp ctl
);
	typedef struct packed {
		logic [5:0] code;
		logic [15:0] tick;
		logic done;
	} ramp_st_t;
	localparam logic [15:0] STEP = 16'(`SS_STEP_CYCLES - 1);
	ramp_st_t st, next_st;
	// Step the code one count per step period, never jump
	always_comb begin
		next_st = st;
		if (!ctl.ramp_run) begin
			next_st = '0;
		end else if (st.code == ctl.target) begin
			next_st.done = 1'b1;
		end else if (st.tick == STEP) begin
			next_st.tick = '0;
			next_st.code = (st.code < ctl.target) ? st.code + 6'd1 :
				st.code - 6'd1;
		end else begin
			next_st.tick = st.tick + 16'd1;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ctl.ref_code = st.code;
	assign ctl.ramp_done = st.done;
endmodule

// ==== design/limit_counter.sv ====
// Counts consecutive switching cycles that end in current limit
`timescale 1ns/10ps
`include "buck_params.svh"
module limit_counter #(
	parameter int RUN = `LIMIT_RUN
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	buck_ctl_if.limit ctl
);
	typedef struct packed {
		logic [4:0] count;
		logic trip;
	} lim_st_t;
	lim_st_t st, next_st;
	// Trip pulses once the run reaches the threshold
	always_comb begin
		next_st = st;
		next_st.trip = 1'b0;
		if (ctl.count_clear) begin
			next_st.count = '0;
		end else if (ctl.cycle_end) begin
			if (!ctl.limit_hit) begin
				next_st.count = '0;
			end else if (st.count == 5'(RUN - 1)) begin
				next_st.count = '0;
				next_st.trip = 1'b1;
			end else begin
				next_st.count = st.count + 5'd1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ctl.trip = st.trip;
endmodule

// ==== design/buck_enable_softstart_control.sv ====
// Enable, soft-start, discharge, restart and mode control of the regulator
`timescale 1ns/10ps
`include "buck_params.svh"
module buck_enable_softstart_control #(
	parameter int RETRY_CYCLES = `RETRY_CYCLES
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hardware_on_pin_i,
	input wire logic setpoint_select_pin_i,
	input wire logic cycle_end_i,
	input wire logic limit_hit_i,
	input wire logic light_load_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic regulator_on_o,
	output logic switch_enable_o,
	output logic sync_rect_enable_o,
	output logic pfm_mode_o,
	output logic bleed_on_o,
	output logic power_good_o,
	output logic [5:0] ref_code_o
);
	typedef struct packed {
		logic [2:0] en_sync;
		logic [2:0] sel_sync;
		logic en_q;
		logic sel_q;
		logic [7:0] setpoint_a;
		logic [7:0] setpoint_b;
		logic [7:0] control;
		logic ack;
		logic [31:0] rdata;
		buck_pkg::seq_state_t state;
		logic [31:0] wait_cnt;
		buck_pkg::light_mode_t lmode;
		logic [2:0] heavy_run;
		logic on;
		logic sw_en;
		logic sr_en;
		logic pfm;
		logic bleed;
		logic pgood;
		logic [5:0] ref_code;
	} ctl_st_t;
	ctl_st_t st, next_st;
	buck_ctl_if ctl();
	logic [7:0] sel_reg;
	logic want_on;
	logic bus_req;

	softstart_ramp u_ramp (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ctl(ctl)
	);

	limit_counter #(
		.RUN(`LIMIT_RUN)
	) u_limit (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ctl(ctl)
	);

	// Selected setpoint register and the combined enable
	assign sel_reg = st.sel_q ? st.setpoint_b : st.setpoint_a;
	assign want_on = st.en_q && sel_reg[`BIT_SW_ON];
	assign bus_req = avs_read_i || avs_write_i;

	// True while the power stage may switch: soft-start or run
	function automatic logic is_live(input buck_pkg::seq_state_t s);
		return (s == buck_pkg::ST_SOFTSTART) || (s == buck_pkg::ST_RUN);
	endfunction

	// Helper module hookups
	assign ctl.target = sel_reg[`CODE_MSB:0];
	assign ctl.ramp_run = is_live(st.state);
	assign ctl.cycle_end = cycle_end_i && st.sw_en;
	assign ctl.limit_hit = limit_hit_i;
	// Counter starts fresh on shutdown and on every restart attempt
	assign ctl.count_clear = !is_live(st.state);

	// Read mux for one register offset
	function automatic logic [31:0] read_word(input logic [7:0] adr,
		input ctl_st_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (adr)
			`OFS_SETPOINT_A: begin
				w = {24'h00_0000, s.setpoint_a};
			end
			`OFS_SETPOINT_B: begin
				w = {24'h00_0000, s.setpoint_b};
			end
			`OFS_CONTROL: begin
				// Only the bleed bit is kept; the rest read zero
				w = {24'h00_0000, s.control[7], 7'h00};
			end
			`OFS_STATUS: begin
				w = {24'h00_0000, s.pgood, 7'h00};
			end
			`OFS_SWITCHING: begin
				w = {28'h000_0000, s.on, s.sw_en, s.sr_en, s.pfm};
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// Pin filter: a new level counts once the last two stages agree
	function automatic logic filt(input logic [2:0] stage,
		input logic q);
		logic v;
		v = q;
		if (stage[2] == stage[1]) begin
			v = stage[2];
		end
		return v;
	endfunction

	// Register write of one byte; unmapped offsets are dropped
	function automatic ctl_st_t write_reg(input ctl_st_t s,
		input logic [7:0] adr, input logic [7:0] v);
		ctl_st_t r;
		r = s;
		case (adr)
			`OFS_SETPOINT_A: begin
				r.setpoint_a = v;
			end
			`OFS_SETPOINT_B: begin
				r.setpoint_b = v;
			end
			`OFS_CONTROL: begin
				r.control = {v[`BIT_BLEED], 7'h00};
			end
			default: begin
				r = s;
			end
		endcase
		return r;
	endfunction

	// Cycles spent off after a limit trip, counted down to zero
	function automatic logic [31:0] retry_load();
		return 32'(RETRY_CYCLES - 1);
	endfunction

	// Sequencer step: decisions on the current state, result on n
	function automatic ctl_st_t seq_step(input ctl_st_t s,
		input ctl_st_t n, input logic want, input logic trip,
		input logic done);
		ctl_st_t r;
		r = n;
		case (s.state)
			buck_pkg::ST_OFF: begin
				if (want) begin
					r.state = buck_pkg::ST_SOFTSTART;
				end
			end
			buck_pkg::ST_SOFTSTART: begin
				if (!want) begin
					r.state = buck_pkg::ST_OFF;
				end else if (trip) begin
					r.state = buck_pkg::ST_RETRY;
					r.wait_cnt = retry_load();
				end else if (done) begin
					r.state = buck_pkg::ST_RUN;
				end
			end
			buck_pkg::ST_RUN: begin
				if (!want) begin
					r.state = buck_pkg::ST_OFF;
				end else if (trip) begin
					r.state = buck_pkg::ST_RETRY;
					r.wait_cnt = retry_load();
				end
			end
			buck_pkg::ST_RETRY: begin
				// Switch node stays tri-stated for the whole wait
				if (!want) begin
					r.state = buck_pkg::ST_OFF;
				end else if (s.wait_cnt == 32'h0000_0000) begin
					r.state = buck_pkg::ST_SOFTSTART;
				end else begin
					r.wait_cnt = s.wait_cnt - 32'h0000_0001;
				end
			end
			default: begin
				r.state = buck_pkg::ST_OFF;
			end
		endcase
		return r;
	endfunction

	// Light-load mode: enter at once, leave after heavy cycles
	function automatic ctl_st_t mode_step(input ctl_st_t s,
		input ctl_st_t n, input logic forced, input logic light);
		ctl_st_t r;
		r = n;
		if (forced) begin
			r.lmode = buck_pkg::LM_PWM;
			r.heavy_run = '0;
		end else if (s.lmode == buck_pkg::LM_PWM) begin
			if (light) begin
				r.lmode = buck_pkg::LM_PFM;
			end
		end else if (!light) begin
			if (s.heavy_run == 3'(`PFM_LEAVE_RUN - 1)) begin
				r.lmode = buck_pkg::LM_PWM;
				r.heavy_run = '0;
			end else begin
				r.heavy_run = s.heavy_run + 3'd1;
			end
		end else begin
			// A light cycle breaks the heavy run
			r.heavy_run = '0;
		end
		return r;
	endfunction

	// Enable pin low: defaults back, every output halted except bleed
	function automatic ctl_st_t shutdown_wipe(input ctl_st_t n);
		ctl_st_t r;
		r = n;
		r.setpoint_a = `RST_SETPOINT;
		r.setpoint_b = `RST_SETPOINT;
		r.control = `RST_CONTROL;
		r.state = buck_pkg::ST_OFF;
		r.lmode = buck_pkg::LM_PWM;
		r.heavy_run = '0;
		r.on = 1'b0;
		r.sw_en = 1'b0;
		r.sr_en = 1'b0;
		r.pfm = 1'b0;
		r.pgood = 1'b0;
		r.ref_code = 6'h00;
		return r;
	endfunction

	// Next state of the whole controller
	always_comb begin
		next_st = st;
		// Pins are asynchronous: three stages before use
		next_st.en_sync = {st.en_sync[1:0], hardware_on_pin_i};
		next_st.sel_sync = {st.sel_sync[1:0], setpoint_select_pin_i};
		next_st.en_q = filt(st.en_sync, st.en_q);
		next_st.sel_q = filt(st.sel_sync, st.sel_q);
		// Slave answers one cycle after a request; a back-to-back request waits one more cycle
		next_st.ack = 1'b0;
		if (bus_req && !st.ack && st.en_q) begin
			next_st.ack = 1'b1;
			next_st.rdata = read_word(avs_address_i, st);
			if (avs_write_i) begin
				next_st = write_reg(next_st, avs_address_i,
					avs_writedata_i[7:0]);
			end
		end else if (bus_req && !st.en_q) begin
			// Refused access still completes so the master never hangs
			next_st.ack = !st.ack;
			next_st.rdata = 32'h0000_0000;
		end
		// Power sequencing
		next_st = seq_step(st, next_st, want_on, ctl.trip,
			ctl.ramp_done);
		// Light-load mode selection, forced off outside run
		next_st = mode_step(st, next_st,
			sel_reg[`BIT_MODE] || (st.state != buck_pkg::ST_RUN),
			light_load_i);
		// Registered outputs
		next_st.on = is_live(next_st.state);
		next_st.sw_en = next_st.on;
		next_st.sr_en = next_st.state == buck_pkg::ST_RUN;
		next_st.pfm = next_st.lmode == buck_pkg::LM_PFM;
		next_st.bleed = st.control[`BIT_BLEED] && !want_on;
		next_st.pgood = next_st.state == buck_pkg::ST_RUN;
		next_st.ref_code = next_st.on ? ctl.ref_code : 6'h00;
		// Low enable pin wipes all settings and halts the power outputs; bleed is not cleared here
		if (!st.en_q) begin
			next_st = shutdown_wipe(next_st);
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
			st.setpoint_a <= `RST_SETPOINT;
			st.setpoint_b <= `RST_SETPOINT;
			st.control <= `RST_CONTROL;
			st.state <= buck_pkg::ST_OFF;
			st.lmode <= buck_pkg::LM_PWM;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = !st.ack;
	assign regulator_on_o = st.on;
	assign switch_enable_o = st.sw_en;
	assign sync_rect_enable_o = st.sr_en;
	assign pfm_mode_o = st.pfm;
	assign bleed_on_o = st.bleed;
	assign power_good_o = st.pgood;
	assign ref_code_o = st.ref_code;
endmodule

// ==== tb/host_model.sv ====
// Host side model: enable pins and register bus master
`timescale 1ns/10ps
module host_model (
	input wire logic clk_i,
	input wire logic avs_waitrequest_i,
	input wire logic [31:0] avs_readdata_i,
	output logic pin_o,
	output logic sel_o,
	output logic [7:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o
);
	// Pins start low so no access is made before power-up
	initial begin
		pin_o = 1'b0;
		sel_o = 1'b0;
		avs_address_o = 8'h00;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0000_0000;
	end
	// Held access; one per three clocks keeps the rate low
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] v, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		avs_address_o <= a;
		avs_writedata_o <= {24'h00_0000, v};
		avs_read_o <= ~w;
		avs_write_o <= w;
		n = 0;
		// Look between edges, where the answer has settled
		do begin
			@(negedge clk_i);
			n++;
		end while (avs_waitrequest_i !== 1'b0 && n < 50);
		q = avs_readdata_i;
		// The coming edge is the one that sees waitrequest low
		@(posedge clk_i);
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		if (n >= 50)
			testbench.hang();
	endtask
endmodule

// ==== tb/buck_ctl_assertions.sv ====
// Concurrent checks on the regulator control ports
`timescale 1ns/10ps
module buck_ctl_checker #(
	parameter int RETRY_CYCLES = 50
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hardware_on_pin_i,
	input wire logic cycle_end_i,
	input wire logic limit_hit_i,
	input wire logic light_load_i,
	input wire logic avs_waitrequest_o,
	input wire logic [31:0] avs_readdata_o,
	input wire logic regulator_on_o,
	input wire logic switch_enable_o,
	input wire logic sync_rect_enable_o,
	input wire logic pfm_mode_o,
	input wire logic bleed_on_o,
	input wire logic power_good_o,
	input wire logic [5:0] ref_code_o
);
	logic [4:0] lim_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Run of consecutive limited cycles while switching
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			lim_cnt <= 5'h00;
		else if (!switch_enable_o || (cycle_end_i && !limit_hit_i))
			lim_cnt <= 5'h00;
		else if (cycle_end_i)
			lim_cnt <= lim_cnt + 5'h01;
	end
	// Port relations of the sequencer
	limit_trip_a: assert property (
		lim_cnt == 5'h0f && cycle_end_i && limit_hit_i
		|-> ##[1:4] !switch_enable_o) else $error("no trip");
	pin_off_a: assert property (
		!hardware_on_pin_i [*8] |-> !regulator_on_o && !switch_enable_o)
		else $error("on while pin low");
	read_zero_a: assert property (
		!hardware_on_pin_i [*8] ##0 !avs_waitrequest_o
		|-> avs_readdata_o == 32'h0000_0000) else $error("read in off");
	ref_off_a: assert property (
		!regulator_on_o [*2] |-> ref_code_o == 6'h00)
		else $error("reference not cleared");
	ramp_step_a: assert property (
		regulator_on_o && !power_good_o && $changed(ref_code_o)
		|-> ref_code_o == $past(ref_code_o) + 6'h01) else $error("ramp jump");
	rect_run_a: assert property (
		sync_rect_enable_o |-> power_good_o && regulator_on_o)
		else $error("rectifier in soft-start");
	bleed_off_a: assert property (
		$rose(bleed_on_o) |-> ##[0:4] !regulator_on_o)
		else $error("bleed while on");
	pulse_entry_a: assert property (
		$rose(pfm_mode_o) |-> $past(light_load_i)) else $error("pulse mode");
endmodule
bind buck_enable_softstart_control buck_ctl_checker #(
	.RETRY_CYCLES(RETRY_CYCLES)
) buck_ctl_checker_inst (
	.clk_i, .nrst_i, .hardware_on_pin_i, .cycle_end_i, .limit_hit_i,
	.light_load_i, .avs_waitrequest_o, .avs_readdata_o, .regulator_on_o,
	.switch_enable_o, .sync_rect_enable_o, .pfm_mode_o, .bleed_on_o,
	.power_good_o, .ref_code_o
);

// ==== tb/testbench.sv ====
// Self-checking bench for the regulator enable and soft-start control
`timescale 1ns/10ps
module testbench;
	localparam int RETRY = 50;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cycle_end_i = 1'b0;
	logic limit_hit_i = 1'b0;
	logic light_load_i = 1'b0;
	logic hardware_on_pin_i, setpoint_select_pin_i, avs_read_i, avs_write_i;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, d;
	logic avs_waitrequest_o, regulator_on_o, switch_enable_o, pfm_mode_o;
	logic sync_rect_enable_o, bleed_on_o, power_good_o;
	logic [5:0] ref_code_o;
	int fail_count = 0;
	int comparisons = 0;
	int n;
	always #25 clk_i = ~clk_i;
	host_model host_model_inst (
		.clk_i,
		.avs_waitrequest_i(avs_waitrequest_o),
		.avs_readdata_i(avs_readdata_o),
		.pin_o(hardware_on_pin_i),
		.sel_o(setpoint_select_pin_i),
		.avs_address_o(avs_address_i),
		.avs_read_o(avs_read_i),
		.avs_write_o(avs_write_i),
		.avs_writedata_o(avs_writedata_i)
	);
	buck_enable_softstart_control #(
		.RETRY_CYCLES(RETRY)
	) buck_enable_softstart_control_inst (
		.clk_i, .nrst_i, .hardware_on_pin_i, .setpoint_select_pin_i,
		.cycle_end_i, .limit_hit_i, .light_load_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .regulator_on_o, .switch_enable_o,
		.sync_rect_enable_o, .pfm_mode_o, .bleed_on_o, .power_good_o,
		.ref_code_o
	);
	// Value and flag comparisons
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t value %h not %h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t flag %b not %b", $time, got, exp);
		end
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task hang;
		fail_count++;
		$display("ERROR %0t wait ran out", $time);
		results;
	endtask
	// Bounded wait for a flag, sampled between edges
	task automatic waitv(ref logic s, input logic v);
		int i;
		i = 0;
		while (s !== v && i < 2000) begin
			@(negedge clk_i);
			i++;
		end
		if (s !== v)
			hang;
	endtask
	// Bus access wrappers and one switching cycle
	task rd(input logic [7:0] a, input logic [31:0] e);
		host_model_inst.access(1'b0, a, 8'h00, d);
		cmp_reg(d, e);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		host_model_inst.access(1'b1, a, v, d);
	endtask
	task pulse(input logic hit);
		@(posedge clk_i);
		cycle_end_i <= 1'b1;
		limit_hit_i <= hit;
		@(posedge clk_i);
		cycle_end_i <= 1'b0;
	endtask
	// Power-up ramp and register defaults
	task t_start;
		@(posedge clk_i);
		host_model_inst.pin_o <= 1'b1;
		waitv(regulator_on_o, 1'b1);
		cmp_bit(sync_rect_enable_o, 1'b0);
		waitv(power_good_o, 1'b1);
		cmp_bit(sync_rect_enable_o, 1'b1);
		cmp_reg({26'h0, ref_code_o}, 32'h0000_0002);
		rd(8'h00, 32'h0000_00c2);
		rd(8'h01, 32'h0000_00c2);
		rd(8'h02, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		$display("test start done");
	endtask
	// Select pin, software bit and discharge
	task t_select;
		wr(8'h01, 8'h42);
		cmp_bit(regulator_on_o, 1'b1);
		@(posedge clk_i);
		host_model_inst.sel_o <= 1'b1;
		waitv(regulator_on_o, 1'b0);
		wr(8'h02, 8'h80);
		waitv(bleed_on_o, 1'b1);
		rd(8'h02, 32'h0000_0080);
		@(posedge clk_i);
		host_model_inst.sel_o <= 1'b0;
		waitv(regulator_on_o, 1'b1);
		waitv(bleed_on_o, 1'b0);
		$display("test select done");
	endtask
	// Light-load mode allowed, then forced off; new setpoint
	task t_mode;
		waitv(power_good_o, 1'b1);
		wr(8'h00, 8'h82);
		light_load_i <= 1'b1;
		waitv(pfm_mode_o, 1'b1);
		wr(8'h00, 8'hc5);
		waitv(pfm_mode_o, 1'b0);
		light_load_i <= 1'b0;
		n = 0;
		while (ref_code_o !== 6'h05 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		cmp_reg({26'h0, ref_code_o}, 32'h0000_0005);
		$display("test mode done");
	endtask
	// Limit run broken by a good cycle, then a full run
	task t_limit;
		repeat (15) pulse(1'b1);
		pulse(1'b0);
		repeat (15) pulse(1'b1);
		repeat (6) @(negedge clk_i);
		cmp_bit(switch_enable_o, 1'b1);
		pulse(1'b1);
		waitv(switch_enable_o, 1'b0);
		n = 0;
		while (switch_enable_o === 1'b0 && n < 1000) begin
			@(negedge clk_i);
			n++;
		end
		cmp_bit(n >= RETRY && n <= RETRY + 4, 1'b1);
		$display("test limit done");
	endtask
	// Pin low: shutdown, refused bus, defaults back
	task t_shutdown;
		wr(8'h01, 8'h45);
		@(posedge clk_i);
		host_model_inst.pin_o <= 1'b0;
		waitv(regulator_on_o, 1'b0);
		rd(8'h01, 32'h0000_0000);
		wr(8'h01, 8'h05);
		@(posedge clk_i);
		host_model_inst.pin_o <= 1'b1;
		waitv(regulator_on_o, 1'b1);
		rd(8'h01, 32'h0000_00c2);
		rd(8'h02, 32'h0000_0000);
		$display("test shutdown done");
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_start;
		t_select;
		t_mode;
		t_limit;
		t_shutdown;
		results;
	end
endmodule
